//--- pac_regs.svh
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH
// Function
// - Capture input on rising edge, hold half cycle.
// - Delay five stage codes into one aligned word.
// - Overlap stages by one bit, correcting flash errors.
// - Apply stored coefficients, giving 14-bit result.
// - Register result and range flag together.
// - Calibrate from back stage forward, store coefficients.
// - Stages four and five get no coefficients.
// - Busy high from start until coefficients stored.
// - Calibration lasts about 1.49 million cycles.
// - Reset aborts calibration, erases coefficients, idles.
// - Outputs belong to calibration while busy.

// =====================================================
// Register map (byte offsets on the slave bus)
`define PAC_CTRL_OFS 4'h0
`define PAC_STATUS_OFS 4'h4
`define PAC_RESULT_OFS 4'h8
`define PAC_CTRL_START_BIT 0
`define PAC_CTRL_FREEZE_BIT 1
`define PAC_CTRL_RESET 1'b0
`define PAC_ST_BUSY_BIT 0
`define PAC_ST_DONE_BIT 1
`define PAC_ST_CODE_LSB 4
`define PAC_ST_STAGE_LSB 8
`define PAC_RES_OOR_BIT 14

// =====================================================
// Pipeline arithmetic
`define PAC_STEP 3
`define PAC_LAST_SHIFT 2
`define PAC_SUM_OFFSET 18'h0_0924
`define PAC_MID 18'h0_2000
`define PAC_OUT_MAX 18'h0_3fff
`define PAC_SHA_STAGE 2'd0
`define PAC_FIRST_STAGE 2'd3
`define PAC_LAST_CODE 4'hf

// =====================================================
// Timing counts
`define PAC_REQ_EDGES 2'd2
`define PAC_CAL_TOTAL_CYCLES 1490000
`define PAC_CAL_POINTS 49
`define PAC_AVG_LOG2 14

`endif

//--- pac_pkg.sv
package pac_pkg;

  // Raw code of one front stage quantizer
  typedef logic [3:0] pac_code_t;

  // Codes of all five stages for one sample
  typedef struct packed {
    pac_code_t [3:0] front;
    logic [2:0] last;
  } pac_codes_t;

  // Converted word as it leaves the pins
  typedef struct packed {
    logic oor;
    logic [13:0] data;
  } pac_result_t;

  // Stored correction for one stage and code
  typedef logic signed [11:0] pac_coef_t;

  typedef enum logic [1:0] {
    PAC_IDLE,
    PAC_SETTLE,
    PAC_MEASURE,
    PAC_STORE
  } pac_state_t;

endpackage

//--- pac_align.sv
module pac_align
  import pac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_strobe,
  input wire pac_codes_t i_codes,
  output pac_codes_t o_codes
);

  // =====================================================
  // Per-stage delay lines
  pac_codes_t aligned_q;
  pac_code_t [3:0] tap;

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_dly
      localparam int D = 4 - k;
      pac_code_t dly_q [D];
      // Earlier stages wait longer so one sample lines up
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          for (int i = 0; i < D; i++) begin
            dly_q[i] <= '0;
          end
        end else if (i_strobe) begin
          dly_q[0] <= i_codes.front[k];
          for (int i = 1; i < D; i++) begin
            dly_q[i] <= dly_q[i-1];
          end
        end
      end
      assign tap[k] = dly_q[D-1];
    end
  endgenerate

  // All five codes registered together
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      aligned_q <= '0;
    end else if (i_strobe) begin
      aligned_q <= '{front: tap, last: i_codes.last};
    end
  end

  assign o_codes = aligned_q;

endmodule

//--- pac_ctrl_top.sv
`include "pac_regs.svh"

module pac_ctrl_top
  import pac_pkg::*;
#(
  parameter int SETTLE_CYCLES =
    `PAC_CAL_TOTAL_CYCLES / `PAC_CAL_POINTS - (1 << `PAC_AVG_LOG2),
  parameter int AVG_LOG2 = `PAC_AVG_LOG2
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cal_req,
  input wire pac_codes_t i_stage_codes,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [13:0] o_data,
  output logic o_out_of_range_flag,
  output logic o_busy,
  output logic o_sha_hold,
  output logic o_cal_switch,
  output logic o_force_en,
  output logic [1:0] o_force_stage,
  output logic [3:0] o_force_code
);

  // =====================================================
  // Constants cut to counter width
  localparam logic [23:0] SETTLE_LAST =
    24'(SETTLE_CYCLES - 1);
  localparam logic [23:0] AVG_LAST =
    24'((1 << AVG_LOG2) - 1);

  // =====================================================
  // Helpers

  // Index into the coefficient memory
  function automatic logic [5:0] coef_idx(
    input logic [1:0] stage,
    input pac_code_t code
  );
    coef_idx = {stage, code};
  endfunction

  // Weighted sum with one overlap bit per stage pair
  function automatic logic [17:0] combine(
    input pac_codes_t c
  );
    logic [17:0] s;
    s = 18'(c.last);
    for (int k = 0; k < 4; k++) begin
      s = s + (18'(c.front[k])
        << (`PAC_LAST_SHIFT + `PAC_STEP * (3 - k)));
    end
    combine = s;
  endfunction

  // =====================================================
  // Declarations
  pac_state_t state_q;
  logic hold_q;
  logic vld_q;
  pac_codes_t al_codes;
  pac_coef_t coef_q [64];
  logic signed [17:0] corr;
  pac_result_t res;
  pac_result_t out_q;
  logic busy_q;
  logic done_q;
  logic [1:0] stage_q;
  pac_code_t code_q;
  logic [23:0] cnt_q;
  logic signed [31:0] acc_q;
  pac_coef_t avg;
  logic [1:0] req_run_q;
  logic req_used_q;
  logic pin_start;
  logic soft_start;
  logic start;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic freeze_q;
  logic req;
  logic accept;
  logic force_en_q;
  logic [5:0] store_idx;

  // =====================================================
  // Sample timing

  // Hold phase follows each conversion rising edge,
  // acquire phase follows the fall
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= ~hold_q;
    end
  end

  // New aligned word is ready one cycle after capture
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      vld_q <= 1'b0;
    end else begin
      vld_q <= ~hold_q;
    end
  end

  // Codes are captured as the hold phase starts
  pac_align u_align (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_strobe(~hold_q),
    .i_codes(i_stage_codes),
    .o_codes(al_codes)
  );

  // =====================================================
  // Correction datapath

  // Overlap sum, then subtract the stored errors.
  // Stages four and five have no entries at all.
  always_comb begin
    corr = $signed(combine(al_codes))
      - $signed(`PAC_SUM_OFFSET)
      - 18'(coef_q[coef_idx(`PAC_SHA_STAGE, 4'h0)])
      - 18'(coef_q[coef_idx(2'd1, al_codes.front[0])])
      - 18'(coef_q[coef_idx(2'd2, al_codes.front[1])])
      - 18'(coef_q[coef_idx(2'd3, al_codes.front[2])]);
  end

  // Clamp to 14 bits and flag anything outside
  always_comb begin
    if (corr < 0) begin
      res = '{oor: 1'b1, data: 14'h0000};
    end else if (corr > $signed(`PAC_OUT_MAX)) begin
      res = '{oor: 1'b1, data: 14'h3fff};
    end else begin
      res = '{oor: 1'b0, data: corr[13:0]};
    end
  end

  // =====================================================
  // Output latch

  // Word and flag change in the same edge; while busy the
  // pins show the calibration point instead of samples
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      out_q <= '0;
    end else if (busy_q) begin
      out_q <= '{oor: 1'b0, data: {8'h00, stage_q, code_q}};
    end else if (vld_q && !freeze_q) begin
      out_q <= res;
    end
  end

  // =====================================================
  // Calibrate request

  // Count consecutive high cycles of the request pin
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      req_run_q <= 2'd0;
    end else if (!i_cal_req) begin
      req_run_q <= 2'd0;
    end else if (req_run_q != 2'd3) begin
      req_run_q <= req_run_q + 2'd1;
    end
  end

  // A request held high starts one calibration only;
  // it must drop before it can start another
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      req_used_q <= 1'b0;
    end else if (!i_cal_req) begin
      req_used_q <= 1'b0;
    end else if (pin_start) begin
      req_used_q <= 1'b1;
    end
  end

  // Third high cycle means more than two falling edges
  assign pin_start = i_cal_req && !req_used_q
    && (req_run_q >= `PAC_REQ_EDGES);
  assign start = (pin_start || soft_start)
    && (state_q == PAC_IDLE);

  // =====================================================
  // Calibration sequencer

  assign avg = pac_coef_t'(acc_q >>> AVG_LOG2);
  assign store_idx = coef_idx(stage_q, code_q);

  // Walks residue amplifiers three, two, one, then the
  // sample-hold; each point settles then averages
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= PAC_IDLE;
      stage_q <= `PAC_FIRST_STAGE;
      code_q <= 4'h0;
      cnt_q <= 24'h00_0000;
    end else begin
      unique case (state_q)
        PAC_IDLE: begin
          if (start) begin
            state_q <= PAC_SETTLE;
            stage_q <= `PAC_FIRST_STAGE;
            code_q <= 4'h0;
            cnt_q <= 24'h00_0000;
          end
        end
        PAC_SETTLE: begin
          if (cnt_q == SETTLE_LAST) begin
            state_q <= PAC_MEASURE;
            cnt_q <= 24'h00_0000;
          end else begin
            cnt_q <= cnt_q + 24'h00_0001;
          end
        end
        PAC_MEASURE: begin
          if (cnt_q == AVG_LAST) begin
            state_q <= PAC_STORE;
          end else begin
            cnt_q <= cnt_q + 24'h00_0001;
          end
        end
        PAC_STORE: begin
          cnt_q <= 24'h00_0000;
          if (stage_q == `PAC_SHA_STAGE) begin
            state_q <= PAC_IDLE;
          end else if (code_q == `PAC_LAST_CODE) begin
            state_q <= PAC_SETTLE;
            stage_q <= stage_q - 2'd1;
            code_q <= 4'h0;
          end else begin
            state_q <= PAC_SETTLE;
            code_q <= code_q + 4'h1;
          end
        end
      endcase
    end
  end

  // Error of the forced code, seen through later stages
  // that already carry their own corrections
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_q <= 32'sh0000_0000;
    end else if (state_q == PAC_SETTLE) begin
      acc_q <= 32'sh0000_0000;
    end else if (state_q == PAC_MEASURE) begin
      acc_q <= acc_q + 32'(corr - $signed(`PAC_MID));
    end
  end

  // Coefficients are added, so a repeat run trims the
  // residue left by the last one; reset wipes them all
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < 64; i++) begin
        coef_q[i] <= '0;
      end
    end else if (state_q == PAC_STORE) begin
      coef_q[store_idx] <= coef_q[store_idx] + avg;
    end
  end

  // Busy covers the whole run, done marks a full set
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (state_q == PAC_STORE
        && stage_q == `PAC_SHA_STAGE) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
  end

  // Force the stage under test; the sample-hold point
  // only needs the input shorted to common mode
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      force_en_q <= 1'b0;
    end else begin
      force_en_q <= (state_q != PAC_IDLE)
        && (stage_q != `PAC_SHA_STAGE);
    end
  end

  // =====================================================
  // Avalon slave

  assign req = i_avs_read || i_avs_write;
  assign accept = req && !wait_q;

  // One wait cycle per access, then a single ready cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  // Read mux; unmapped offsets return zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (i_avs_address)
      `PAC_CTRL_OFS: begin
        rd_d[`PAC_CTRL_FREEZE_BIT] = freeze_q;
      end
      `PAC_STATUS_OFS: begin
        rd_d[`PAC_ST_BUSY_BIT] = busy_q;
        rd_d[`PAC_ST_DONE_BIT] = done_q;
        rd_d[`PAC_ST_CODE_LSB +: 4] = code_q;
        rd_d[`PAC_ST_STAGE_LSB +: 2] = stage_q;
      end
      `PAC_RESULT_OFS: begin
        rd_d[`PAC_RES_OOR_BIT:0] = out_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // Data is loaded as waitrequest drops and stands then
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read && wait_q) begin
      rdata_q <= rd_d;
    end
  end

  assign soft_start = accept && i_avs_write
    && (i_avs_address == `PAC_CTRL_OFS) && i_avs_byteenable[0]
    && i_avs_writedata[`PAC_CTRL_START_BIT];

  // Freeze holds the pins on the last converted word while not busy; busy still loads the calibration point
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      freeze_q <= `PAC_CTRL_RESET;
    end else if (accept && i_avs_write
        && i_avs_address == `PAC_CTRL_OFS
        && i_avs_byteenable[0]) begin
      freeze_q <= i_avs_writedata[`PAC_CTRL_FREEZE_BIT];
    end
  end

  // =====================================================
  // Outputs, all straight from flops

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_data = out_q.data;
  assign o_out_of_range_flag = out_q.oor;
  assign o_busy = busy_q;
  assign o_sha_hold = hold_q;
  assign o_cal_switch = busy_q;
  assign o_force_en = force_en_q;
  assign o_force_stage = stage_q;
  assign o_force_code = code_q;

endmodule

//--- pac_ctrl_checker.sv
module pac_ctrl_checker
  import pac_pkg::*;
#(
  parameter int SETTLE_CYCLES = 4,
  parameter int AVG_LOG2 = 2
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cal_req,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [13:0] o_data,
  input wire logic o_out_of_range_flag,
  input wire logic o_busy,
  input wire logic o_sha_hold,
  input wire logic o_cal_switch,
  input wire logic [1:0] o_force_stage,
  input wire logic [3:0] o_force_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================
  // Busy span counter
  localparam int SPAN = 49 * (SETTLE_CYCLES + (1 << AVG_LOG2) + 1) + 1;
  logic [31:0] span_q;

  // Counts busy cycles; a small slack absorbs the start and end cycles
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) span_q <= '0;
    else if (o_busy) span_q <= span_q + 32'h0000_0001;
    else span_q <= '0;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // =====================================================
  // Properties
  AST_HOLD_TOGGLE: assert property (!o_sha_hold |=> o_sha_hold) else $error("hold phase missed");
  AST_CAL_START: assert property ((i_cal_req && !o_busy) [*3] |=> o_busy) else $error("start not taken");
  AST_CAL_CAUSE: assert property ($rose(o_busy) |-> $past(i_cal_req, 2) && $past(i_cal_req, 3))
    else $error("busy without a long request");
  AST_BACK_FIRST: assert property ($rose(o_busy) |-> o_force_stage == 2'd3 && o_force_code == 4'h0)
    else $error("calibration not from back stage");
  AST_STAGE_ORDER: assert property (o_busy && $past(o_busy) |-> o_force_stage <= $past(o_force_stage))
    else $error("stage order broken or restarted");
  AST_CAL_OUTPUTS: assert property (o_busy && $past(o_busy)
    |-> o_data[13:6] == 8'h00 && !o_out_of_range_flag) else $error("outputs not under calibration");
  AST_SWITCH: assert property (o_cal_switch == o_busy) else $error("input switch wrong");
  AST_SPAN_MAX: assert property (o_busy |-> span_q <= SPAN + 2) else $error("calibration too long");
  AST_SPAN_MIN: assert property ($fell(o_busy) |-> span_q + 2 >= SPAN) else $error("calibration too short");
  AST_CLAMP: assert property (o_out_of_range_flag && !o_busy
    |-> o_data == 14'h0000 || o_data == 14'h3fff) else $error("range flag without clamp");
  AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
endmodule

bind pac_ctrl_top pac_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES), .AVG_LOG2(AVG_LOG2)) u_pac_ctrl_checker (
  .i_clk, .i_reset, .i_cal_req, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_data,
  .o_out_of_range_flag, .o_busy, .o_sha_hold, .o_cal_switch, .o_force_stage, .o_force_code);

//--- pac_far_end.sv
module pac_far_end (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_go,
  input wire logic [3:0] i_len,
  output logic o_cal_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] since_q;
  logic [3:0] left_q;

  // =====================================================
  // Request sequencing
  // Cycles since reset release; an early request would meet unsettled bias
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) since_q <= '0;
    else if (since_q != 2'd3) since_q <= since_q + 2'd1;
  end

  // Request level held for the commanded count of cycles
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) left_q <= '0;
    else if (i_go && since_q >= 2'd2) left_q <= i_len;
    else if (left_q != 4'h0) left_q <= left_q - 4'h1;
  end
  assign o_cal_req = (left_q != 4'h0);
endmodule

//--- testbench.sv
`include "pac_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pac_pkg::*;
  typedef struct packed {pac_codes_t c; logic [13:0] d; logic oor;} pac_row_t;
  logic i_clk, i_reset, go, cal_req, rd, wr, wait_req, oor, busy, hold, sw, fen;
  logic [3:0] len, adr, fcode;
  logic [31:0] wd, rdat, avs_rdata;
  logic [13:0] data;
  logic [1:0] fst;
  pac_codes_t codes;
  pac_row_t rows [5];
  int bad_count = 0;
  int n_compared = 0;
  int cnt;

  pac_ctrl_top #(.SETTLE_CYCLES(4), .AVG_LOG2(2)) u_pac_ctrl_top (.i_clk(i_clk), .i_reset(i_reset),
    .i_cal_req(cal_req), .i_stage_codes(codes), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(wait_req),
    .o_data(data), .o_out_of_range_flag(oor), .o_busy(busy), .o_sha_hold(hold), .o_cal_switch(sw),
    .o_force_en(fen), .o_force_stage(fst), .o_force_code(fcode));
  pac_far_end u_pac_far_end (.i_clk(i_clk), .i_reset(i_reset), .i_go(go), .i_len(len), .o_cal_req(cal_req));

  // =====================================================
  // Tasks
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Request held until the rising edge that sees waitrequest low;
  // data is taken and the request dropped at that same edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge i_clk); while (wait_req !== 1'b0);
    rdat = avs_rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task pulse_req(input logic [3:0] n);
    @(posedge i_clk);
    go <= 1'b1;
    len <= n;
    @(posedge i_clk);
    go <= 1'b0;
  endtask

  task wait_busy(input logic v);
    cnt = 0;
    do begin
      @(negedge i_clk);
      cnt++;
    end while (busy !== v && cnt < 2000);
  endtask

  // Settled output after the pipeline has flushed a held code set
  task settle_and_check(input int i);
    @(posedge i_clk);
    codes <= rows[i].c;
    repeat (24) @(posedge i_clk);
    @(negedge i_clk);
    check("data", data, rows[i].d);
    check("range", oor, rows[i].oor);
  endtask

  // =====================================================
  // Clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end

  // =====================================================
  // Main sequence
  initial begin
    i_reset = 1'b1;
    go = 1'b0;
    len = 4'h0;
    codes = '0;
    adr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = '0;
    rows[0] = {16'h1111, 3'h0, 14'h0000, 1'b0};
    rows[1] = {16'h0000, 3'h0, 14'h0000, 1'b1};
    rows[2] = {16'h4444, 3'h2, 14'h1b6e, 1'b0};
    rows[3] = {16'h0123, 3'h1, 14'h10fd, 1'b0};
    rows[4] = {16'h8888, 3'h4, 14'h3fff, 1'b1};
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) settle_and_check(i);
    // Unmapped place: write ignored, read gives zero
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0000_0000);
    check("unmapped", rdat, 32'h0000_0000);
    // Freeze holds the output word while codes move
    bus(1'b1, `PAC_CTRL_OFS, 32'h0000_0002);
    codes <= rows[2].c;
    repeat (24) @(posedge i_clk);
    @(negedge i_clk);
    check("frozen", data, 14'h3fff);
    bus(1'b0, `PAC_CTRL_OFS, 32'h0000_0000);
    check("ctrl", rdat, 32'h0000_0002);
    bus(1'b0, `PAC_RESULT_OFS, 32'h0000_0000);
    check("result", rdat, 32'h0000_7fff);
    bus(1'b1, `PAC_CTRL_OFS, 32'h0000_0000);
    // Two high cycles are too short to start
    pulse_req(4'h2);
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    check("short request", busy, 1'b0);
    pulse_req(4'h3);
    wait_busy(1'b1);
    check("busy late", cnt, 4);
    bus(1'b0, `PAC_STATUS_OFS, 32'h0000_0000);
    check("status busy", rdat[1:0], 2'b01);
    pulse_req(4'h3);
    wait_busy(1'b0);
    check("busy span", cnt > 420 && cnt < 450, 1'b1);
    bus(1'b0, `PAC_STATUS_OFS, 32'h0000_0000);
    check("status done", rdat[1:0], 2'b10);
    // The held input was measured at mid-scale, so it now reads mid-scale
    repeat (24) @(posedge i_clk);
    @(negedge i_clk);
    check("calibrated", data, 14'h2000);
    // Abort in mid-run, then coefficients must be gone
    pulse_req(4'h3);
    wait_busy(1'b1);
    repeat (100) @(posedge i_clk);
    i_reset <= 1'b1;
    @(negedge i_clk);
    check("abort", {busy, sw, fen, fst, wait_req}, {3'h0, 2'd3, 1'b1});
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    bus(1'b0, `PAC_STATUS_OFS, 32'h0000_0000);
    check("status idle", rdat[1:0], 2'b00);
    settle_and_check(3);
    tally_and_finish;
  end
endmodule
